/* hdl/dmcca_pkg.sv */
// Constants shared by the dual-unit capture/compare counter array.
// Assumes a single 20 MHz clock and an Avalon-MM register port with 32-bit data.
//
// What this block does
// RULE1 - Counter clocked from one of four sources.
// RULE2 - Select 01 is clock/2, 10 timer0 overflow.
// RULE3 - Select 00 is clock/6, 11 external pin.
// RULE4 - One shared 16-bit counter for both units.
// RULE5 - Idle-stop bit halts counter during idle.
// RULE6 - Counter advances only while run bit set.
// RULE7 - Rollover sets sticky overflow flag, software clears.
// RULE8 - Unit hit or capture sets its event flag.
// RULE9 - Unit flag interrupts only when enabled.
// RULE10 - All interrupt sources merge into one output.
// RULE11 - Falling/rising grab bits choose capture edges.
// RULE12 - Valid edge copies counter into grab registers.
// RULE13 - Comparator plus hit flag gives software timer.
// RULE14 - Counter equal compare sets flag if enabled.
// RULE15 - Comparison works only with comparator enabled; PWM mode compares without UM_CMP_EN.
// RULE16 - Toggle bit inverts unit pin on hit.
// RULE17 - Toggle, hit flag, comparator give high-speed output.
// RULE18 - Modulation bit selects 8-bit PWM mode.
// RULE19 - PWM low below duty; reload on wrap.
// RULE20 - Pins P1.2..P1.4 used; otherwise ordinary I/O.
// RULE21 - External inputs synchronised, edges by sample compare.
`default_nettype none

package dmcca_pkg;

  // ==========================================================================
  // Register byte offsets on the Avalon-MM port.
  localparam logic [5:0] OFF_MODE      = 6'h00;
  localparam logic [5:0] OFF_CTL       = 6'h04;
  localparam logic [5:0] OFF_CNT_LO    = 6'h08;
  localparam logic [5:0] OFF_CNT_HI    = 6'h0c;
  localparam logic [5:0] OFF_UMODE     = 6'h10;
  localparam logic [5:0] OFF_UMODE_STP = 6'h04;
  localparam logic [5:0] OFF_GRAB_LO   = 6'h18;
  localparam logic [5:0] OFF_GRAB_HI   = 6'h1c;
  localparam logic [5:0] OFF_GRAB_STP  = 6'h08;

  // ==========================================================================
  // Field positions in the array mode and control registers.
  localparam int MODE_IDLE_STOP = 7;
  localparam int MODE_SEL_HI    = 2;
  localparam int MODE_SEL_LO    = 1;
  localparam int MODE_OVF_EN    = 0;
  localparam int CTL_OVF_FLAG   = 7;
  localparam int CTL_RUN        = 6;

  // Field positions in each unit mode register.
  localparam int UM_CMP_EN  = 6;
  localparam int UM_RISE_EN = 5;
  localparam int UM_FALL_EN = 4;
  localparam int UM_HIT_EN  = 3;
  localparam int UM_FLIP    = 2;
  localparam int UM_MOD_EN  = 1;
  localparam int UM_IRQ_EN  = 0;
  localparam int UM_W       = 7;

  // ==========================================================================
  // Reset values and count-source codes.
  localparam logic [UM_W-1:0] UMODE_RST = 7'h00;
  localparam logic [15:0]     CNT_RST   = 16'h0000;
  localparam logic [15:0]     CNT_MAX   = 16'hffff;
  localparam logic [1:0] SRC_DIV6 = 2'h0;
  localparam logic [1:0] SRC_DIV2 = 2'h1;
  localparam logic [1:0] SRC_T0   = 2'h2;
  localparam logic [1:0] SRC_EXT  = 2'h3;

  // ==========================================================================
  // Prescaler: one counter serves both divide ratios.
  localparam int          DIV_SLOW = 6;
  localparam int          DIV_FAST = 2;
  localparam logic [2:0]  PRE_LAST = 3'(DIV_SLOW - 1);
  localparam int          NUM_UNITS = 2;

endpackage : dmcca_pkg

`default_nettype wire

/* hdl/dmcca_unit_if.sv */
// Interface joining the array top to one capture/compare unit.
// Assumes both ends sit on the same clock.
`default_nettype none

interface dmcca_unit_if;
  logic [15:0] cnt;        // Shared counter value.
  logic        cnt_adv;    // Counter just advanced.
  logic        rise;       // Synchronised rising edge on unit pin.
  logic        fall;       // Synchronised falling edge on unit pin.
  logic [6:0]  mode;       // Unit mode register.
  logic        wr_lo;      // Software write to grab low byte.
  logic        wr_hi;      // Software write to grab high byte.
  logic [7:0]  wdata;      // Write data byte.
  logic [15:0] grab;       // Grab/compare registers.
  logic        evt;        // Hit or capture event pulse.
  logic        pin_out;    // Unit pin level.
  logic        pin_drive;  // Unit owns its pin.

  modport ctl  (output cnt, cnt_adv, rise, fall, mode, wr_lo, wr_hi, wdata,
                input  grab, evt, pin_out, pin_drive);
  modport unit (input  cnt, cnt_adv, rise, fall, mode, wr_lo, wr_hi, wdata,
                output grab, evt, pin_out, pin_drive);
endinterface : dmcca_unit_if

`default_nettype wire

/* hdl/dmcca_sync.sv */
// Three-stage input synchroniser with edge pulses per bit.
// Assumes the inputs are asynchronous pins; outputs are on ref_clk_i.
`default_nettype none

module dmcca_sync
  import dmcca_pkg::*;
#(
  parameter int WIDTH = 3
) (
  // Clock and reset.
  input  wire logic             ref_clk_i,
  input  wire logic             rst_b_i,
  // Raw pins and filtered results.
  input  wire logic [WIDTH-1:0] pin_i,
  output logic      [WIDTH-1:0] rise_o,
  output logic      [WIDTH-1:0] fall_o
);

  logic [WIDTH-1:0] s1_q, s2_q, s3_q, lvl_q;

  // Agreement is judged bit by bit, so each pin filters on its own and a
  // change on one pin never masks or fakes an edge on another.
  wire [WIDTH-1:0] agree = ~(s2_q ^ s3_q);                         // see RULE21
  wire [WIDTH-1:0] lvl_d = (agree & s3_q) | (~agree & lvl_q);      // see RULE21

  // ==========================================================================
  // A change counts only when stages two and three agree, so a sample
  // caught mid-transition never produces a double edge.
  always_ff @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      s1_q   <= '0;
      s2_q   <= '0;
      s3_q   <= '0;
      lvl_q  <= '0;
      rise_o <= '0;
      fall_o <= '0;
    end
    else
    begin
      s1_q   <= pin_i;
      s2_q   <= s1_q;
      s3_q   <= s2_q;
      lvl_q  <= lvl_d;                                            // see RULE21
      rise_o <= agree & s3_q & ~lvl_q;                            // see RULE21
      fall_o <= agree & ~s3_q & lvl_q;                            // see RULE21
    end
  end

endmodule : dmcca_sync

`default_nettype wire

/* hdl/dmcca_unit.sv */
// One capture/compare unit: capture, software timer, toggle output, PWM.
// Assumes the shared counter and synchronised edges come from the array top.
`default_nettype none

module dmcca_unit
  import dmcca_pkg::*;
(
  // Clock and reset.
  input  wire logic   ref_clk_i,
  input  wire logic   rst_b_i,
  // Link to the array top.
  dmcca_unit_if.unit  u
);

  logic [15:0] grab_q;
  logic        pin_q;

  // ==========================================================================
  // Event decode from the mode bits.
  wire cmp_hit = u.cnt_adv & u.mode[UM_CMP_EN] & ~u.mode[UM_MOD_EN]
                 & (u.cnt == grab_q);                             // see RULE13 see RULE15
  wire cap     = (u.rise & u.mode[UM_RISE_EN])
               | (u.fall & u.mode[UM_FALL_EN]);                   // see RULE11
  wire reload  = u.cnt_adv & u.mode[UM_MOD_EN] & (u.cnt[7:0] == 8'h00);
  // The duty byte in use during the wrap cycle is the fresh one, so the
  // first period after an update is already correct.
  wire [7:0] duty = reload ? grab_q[15:8] : grab_q[7:0];
  wire [7:0] lo_d = cap ? u.cnt[7:0] : u.wr_lo ? u.wdata
                  : reload ? grab_q[15:8] : grab_q[7:0];          // see RULE12 see RULE19
  wire [7:0] hi_d = cap ? u.cnt[15:8] : u.wr_hi ? u.wdata : grab_q[15:8];  // see RULE12
  wire pin_d = u.mode[UM_MOD_EN] ? (u.cnt[7:0] >= duty)           // see RULE18 see RULE19
             : (cmp_hit & u.mode[UM_FLIP]) ? ~pin_q : pin_q;      // see RULE16 see RULE17

  // ==========================================================================
  // Grab registers and output pin state. Capture beats a software write.
  always_ff @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      grab_q <= CNT_RST;
      pin_q  <= 1'b0;
    end
    else
    begin
      grab_q <= {hi_d, lo_d};
      pin_q  <= pin_d;
    end
  end

  // Outputs to the top.
  assign u.grab      = grab_q;
  assign u.pin_out   = pin_q;
  assign u.pin_drive = u.mode[UM_MOD_EN] | u.mode[UM_FLIP];
  assign u.evt       = cap | (cmp_hit & u.mode[UM_HIT_EN]);       // see RULE8 see RULE14

endmodule : dmcca_unit

`default_nettype wire

/* hdl/dmcca_top.sv */
// Dual-unit capture/compare counter array with an Avalon-MM register port.
// Assumes pins P1.2..P1.4 arrive asynchronously and the timer 0 overflow
// pulse and idle level come from logic on ref_clk_i.
`default_nettype none

module dmcca_top
  import dmcca_pkg::*;
(
  // Clock and reset.
  input  wire logic        ref_clk_i,
  input  wire logic        rst_b_i,
  // Avalon-MM slave.
  input  wire logic [5:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  output logic      [31:0] avs_readdata_o,
  output logic             avs_waitrequest_o,
  // System events.
  input  wire logic        idle_i,
  input  wire logic        t0_ovf_i,
  output logic             irq_o,
  // Port bits 2..4: bit 0 here is P1.2, bit 1 P1.3, bit 2 P1.4.
  input  wire logic [2:0]  pin_i,
  output logic      [2:0]  pin_o,
  output logic      [2:0]  pin_oe_b_o,
  // Ordinary port logic used when the array leaves a pin alone.
  input  wire logic [2:0]  gpio_out_i,
  input  wire logic [2:0]  gpio_oe_b_i
);

  // ==========================================================================
  // Registers.
  logic            idle_stop_ctl_q, count_source_sel_hi_q, count_source_sel_lo_q;
  logic            overflow_irq_en_q, overflow_flag_q, run_ctl_q;
  logic [1:0]      unit_event_flag_q;
  logic [UM_W-1:0] unit_mode_q [NUM_UNITS];
  logic [15:0]     cnt_q;
  logic [2:0]      pre_q;
  logic            cnt_adv_q, ack_q, irq_q;
  logic [31:0]     rdata_q;
  logic [2:0]      rise, fall;
  logic [1:0]      u_evt, u_drive, u_pin, u_rd_hit;
  logic [7:0]      u_rd [NUM_UNITS];

  // ==========================================================================
  // Bus handshake: one wait state for every access. A write lands at the
  // edge where waitrequest is seen low; read data are loaded one edge earlier.
  wire        req    = avs_read_i | avs_write_i;
  wire        wr_ok  = avs_write_i & ack_q & avs_byteenable_i[0];
  wire [7:0]  wbyte  = avs_writedata_i[7:0];
  wire        wr_mode = wr_ok & (avs_address_i == OFF_MODE);
  wire        wr_ctl  = wr_ok & (avs_address_i == OFF_CTL);
  wire        wr_clo  = wr_ok & (avs_address_i == OFF_CNT_LO);
  wire        wr_chi  = wr_ok & (avs_address_i == OFF_CNT_HI);
  assign avs_waitrequest_o = req & ~ack_q;
  assign avs_readdata_o    = rdata_q;

  // ==========================================================================
  // Input synchronisers for the count pin and both unit pins.
  dmcca_sync #(.WIDTH(3)) u_sync (
    .ref_clk_i (ref_clk_i),
    .rst_b_i   (rst_b_i),
    .pin_i     (pin_i),                                          // see RULE21
    .rise_o    (rise),
    .fall_o    (fall)
  );

  // ==========================================================================
  // Count source selection. One free prescaler serves both ratios: its low
  // bit is high every second cycle, its last value every sixth.
  wire [1:0] src_sel  = {count_source_sel_hi_q, count_source_sel_lo_q};
  wire       tick_d6  = (pre_q == PRE_LAST);
  wire       tick_d2  = pre_q[0];
  wire       src_tick = (src_sel == SRC_DIV6) ? tick_d6          // see RULE3
                      : (src_sel == SRC_DIV2) ? tick_d2          // see RULE2
                      : (src_sel == SRC_T0)   ? t0_ovf_i         // see RULE2
                      : fall[0];                                 // see RULE1 see RULE3
  wire       counting = run_ctl_q & ~(idle_i & idle_stop_ctl_q);  // see RULE5 see RULE6
  wire       cnt_inc  = counting & src_tick;                      // see RULE1
  wire       ovf_set  = cnt_inc & (cnt_q == CNT_MAX);             // see RULE7
  wire [15:0] cnt_d   = wr_clo ? {cnt_q[15:8], wbyte}
                      : wr_chi ? {wbyte, cnt_q[7:0]}
                      : cnt_inc ? cnt_q + 16'h0001 : cnt_q;       // see RULE4

  // Prescaler and shared counter.
  always_ff @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      pre_q     <= 3'h0;
      cnt_q     <= CNT_RST;
      cnt_adv_q <= 1'b0;
    end
    else
    begin
      pre_q     <= tick_d6 ? 3'h0 : pre_q + 3'h1;
      cnt_q     <= cnt_d;
      cnt_adv_q <= cnt_inc;
    end
  end

  // ==========================================================================
  // Units. Each sees the same counter and its own pin edges.
  genvar gi;
  generate
    for (gi = 0; gi < NUM_UNITS; gi++)
    begin : g_unit
      dmcca_unit_if u_if ();
      localparam logic [5:0] A_MODE = 6'(OFF_UMODE + gi * OFF_UMODE_STP);
      localparam logic [5:0] A_LO   = 6'(OFF_GRAB_LO + gi * OFF_GRAB_STP);
      localparam logic [5:0] A_HI   = 6'(OFF_GRAB_HI + gi * OFF_GRAB_STP);
      wire sel_mode = (avs_address_i == A_MODE);
      wire sel_lo   = (avs_address_i == A_LO);
      wire sel_hi   = (avs_address_i == A_HI);
      assign u_if.cnt     = cnt_q;                                // see RULE4
      assign u_if.cnt_adv = cnt_adv_q;
      assign u_if.rise    = rise[gi+1];
      assign u_if.fall    = fall[gi+1];
      assign u_if.mode    = unit_mode_q[gi];
      assign u_if.wr_lo   = wr_ok & sel_lo;
      assign u_if.wr_hi   = wr_ok & sel_hi;
      assign u_if.wdata   = wbyte;
      assign u_evt[gi]    = u_if.evt;
      assign u_drive[gi]  = u_if.pin_drive;
      assign u_pin[gi]    = u_if.pin_out;
      assign u_rd_hit[gi] = sel_mode | sel_lo | sel_hi;
      assign u_rd[gi]     = sel_mode ? {1'b0, unit_mode_q[gi]}
                          : sel_lo ? u_if.grab[7:0]
                          : sel_hi ? u_if.grab[15:8] : 8'h00;
      // Unit pin goes to the port only while the unit owns it.
      assign pin_o[gi+1]      = u_if.pin_drive ? u_if.pin_out : gpio_out_i[gi+1];     // see RULE20
      assign pin_oe_b_o[gi+1] = u_if.pin_drive ? 1'b0 : gpio_oe_b_i[gi+1];           // see RULE20
      dmcca_unit u_unit (
        .ref_clk_i (ref_clk_i),
        .rst_b_i   (rst_b_i),
        .u         (u_if.unit)
      );
    end
  endgenerate

  // The count pin is input only for the array, so the port keeps driving it.
  assign pin_o[0]      = gpio_out_i[0];                          // see RULE20
  assign pin_oe_b_o[0] = gpio_oe_b_i[0];

  // ==========================================================================
  // Read mux: unmapped addresses read as zero.
  wire [7:0] rd_mode = {idle_stop_ctl_q, 4'h0, count_source_sel_hi_q,
                        count_source_sel_lo_q, overflow_irq_en_q};
  wire [7:0] rd_ctl  = {overflow_flag_q, run_ctl_q, 4'h0, unit_event_flag_q};
  wire [7:0] rd_byte = (avs_address_i == OFF_MODE)   ? rd_mode
                     : (avs_address_i == OFF_CTL)    ? rd_ctl
                     : (avs_address_i == OFF_CNT_LO) ? cnt_q[7:0]
                     : (avs_address_i == OFF_CNT_HI) ? cnt_q[15:8]
                     : (|u_rd_hit) ? (u_rd[0] | u_rd[1]) : 8'h00;

  // ==========================================================================
  // Flags: a hardware set in the same cycle as a software clear wins, so no
  // event is lost. Software writes a zero to clear.
  wire       ovf_flag_d = ovf_set | (wr_ctl ? wbyte[CTL_OVF_FLAG] : overflow_flag_q);  // see RULE7
  wire [1:0] uflag_d    = u_evt | (wr_ctl ? wbyte[1:0] : unit_event_flag_q);          // see RULE8
  wire [1:0] u_irq_en   = {unit_mode_q[1][UM_IRQ_EN], unit_mode_q[0][UM_IRQ_EN]};
  wire       irq_d      = (ovf_flag_d & overflow_irq_en_q)
                        | (|(uflag_d & u_irq_en));               // see RULE9 see RULE10

  // Control registers and bus answer.
  always_ff @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      idle_stop_ctl_q       <= 1'b0;
      count_source_sel_hi_q <= 1'b0;
      count_source_sel_lo_q <= 1'b0;
      overflow_irq_en_q     <= 1'b0;
      overflow_flag_q       <= 1'b0;
      run_ctl_q             <= 1'b0;
      unit_event_flag_q     <= 2'h0;
      unit_mode_q           <= '{default: UMODE_RST};
      ack_q                 <= 1'b0;
      rdata_q               <= 32'h0000_0000;
      irq_q                 <= 1'b0;
    end
    else
    begin
      if (wr_mode)
      begin
        idle_stop_ctl_q       <= wbyte[MODE_IDLE_STOP];
        count_source_sel_hi_q <= wbyte[MODE_SEL_HI];
        count_source_sel_lo_q <= wbyte[MODE_SEL_LO];
        overflow_irq_en_q     <= wbyte[MODE_OVF_EN];
      end
      if (wr_ctl)
        run_ctl_q <= wbyte[CTL_RUN];                              // see RULE6
      for (int i = 0; i < NUM_UNITS; i++)
        if (g_unit_sel(i))
          unit_mode_q[i] <= wbyte[UM_W-1:0];
      overflow_flag_q   <= ovf_flag_d;
      unit_event_flag_q <= uflag_d;
      ack_q             <= req & ~ack_q;
      if (avs_read_i & ~ack_q)
        rdata_q <= {24'h00_0000, rd_byte};
      irq_q <= irq_d;
    end
  end

  // Unit mode write decode, kept as a function to stay inside the process.
  function automatic logic g_unit_sel(input int idx);
    g_unit_sel = wr_ok & (avs_address_i == 6'(OFF_UMODE + idx * OFF_UMODE_STP));
  endfunction : g_unit_sel

  assign irq_o = irq_q;

  // ==========================================================================
  // Assertions.
  wire wr_cnt = wr_clo | wr_chi;

  property p_div6;
    @(posedge ref_clk_i) disable iff (!rst_b_i)
    (cnt_inc && src_sel == SRC_DIV6) |=> !cnt_inc [*5] ##1 (cnt_inc || !counting);
  endproperty
  a_div6: assert property (p_div6) else $error("clock/6 spacing wrong"); // see RULE3

  property p_div2;
    @(posedge ref_clk_i) disable iff (!rst_b_i)
    (cnt_inc && src_sel == SRC_DIV2 && counting) |=> !cnt_inc ##1 (cnt_inc || !counting);
  endproperty
  a_div2: assert property (p_div2) else $error("clock/2 spacing wrong"); // see RULE2

  property p_t0;
    @(posedge ref_clk_i) disable iff (!rst_b_i)
    (src_sel == SRC_T0 && counting && t0_ovf_i && !wr_cnt) |=> cnt_q == $past(cnt_q) + 16'h0001;
  endproperty
  a_t0: assert property (p_t0) else $error("timer0 overflow not counted"); // see RULE2

  property p_run;
    @(posedge ref_clk_i) disable iff (!rst_b_i)
    (!run_ctl_q && !wr_cnt) |=> $stable(cnt_q);
  endproperty
  a_run: assert property (p_run) else $error("counter moved while stopped"); // see RULE6

  property p_idle;
    @(posedge ref_clk_i) disable iff (!rst_b_i)
    (idle_i && idle_stop_ctl_q && !wr_cnt) |=> $stable(cnt_q);
  endproperty
  a_idle: assert property (p_idle) else $error("counter moved in idle"); // see RULE5

  property p_ovf;
    @(posedge ref_clk_i) disable iff (!rst_b_i)
    ovf_set |=> overflow_flag_q && cnt_q == CNT_RST ##1 (overflow_flag_q || $past(wr_ctl));
  endproperty
  a_ovf: assert property (p_ovf) else $error("overflow flag not set"); // see RULE7

  property p_irq;
    @(posedge ref_clk_i) disable iff (!rst_b_i)
    (overflow_flag_q && overflow_irq_en_q) || (unit_event_flag_q[0] && u_irq_en[0])
      |-> irq_o || $past(irq_d) == 1'b0 && irq_q == 1'b0 && irq_d;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt missing"); // see RULE10

  property p_cap0;
    @(posedge ref_clk_i) disable iff (!rst_b_i)
    (rise[1] && unit_mode_q[0][UM_RISE_EN]) |=> g_unit[0].u_if.grab == $past(cnt_q)
      && unit_event_flag_q[0];
  endproperty
  a_cap0: assert property (p_cap0) else $error("capture missed"); // see RULE12

  property p_flip0;
    @(posedge ref_clk_i) disable iff (!rst_b_i)
    (g_unit[0].u_unit.cmp_hit && unit_mode_q[0][UM_FLIP]) |=> u_pin[0] != $past(u_pin[0]);
  endproperty
  a_flip0: assert property (p_flip0) else $error("toggle missed"); // see RULE16

  property p_wait;
    @(posedge ref_clk_i) disable iff (!rst_b_i)
    (req && avs_waitrequest_o) |=> (req |-> !avs_waitrequest_o);
  endproperty
  a_wait: assert property (p_wait) else $error("wait longer than one cycle");

  c_ovf:  cover property (@(posedge ref_clk_i) disable iff (!rst_b_i) ovf_set);
  c_cap:  cover property (@(posedge ref_clk_i) disable iff (!rst_b_i) u_evt[1] && unit_mode_q[1][UM_FALL_EN]);
  c_pwm:  cover property (@(posedge ref_clk_i) disable iff (!rst_b_i) unit_mode_q[0][UM_MOD_EN] && $rose(u_pin[0]));
  c_irq:  cover property (@(posedge ref_clk_i) disable iff (!rst_b_i) $rose(irq_o));

endmodule : dmcca_top

`default_nettype wire

/* tb/dmcca_pin_model.sv */
// Far-side model of port bits P1.2..P1.4 for the counter array.
// Assumes the bench sets the levels that outside parts put on free pins.
`default_nettype none

module dmcca_pin_model (
  // Far-side levels and array drive.
  input  wire logic [2:0] lvl_i,
  input  wire logic [2:0] drv_i,
  input  wire logic [2:0] oe_b_i,
  // Resolved wire level.
  output logic      [2:0] wire_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // The array wins where it drives, so a pin it owns reads back its own level.
  assign wire_o = (drv_i & ~oe_b_i) | (lvl_i & oe_b_i);
endmodule : dmcca_pin_model

`default_nettype wire

/* tb/dmcca_top_tb.sv */
// Self-checking bench for the dual-unit capture/compare array.
// Assumes one wait state per bus request and the pin model on P1.2..P1.4.
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin n_fail++; \
  $display("ERROR %s expected %h seen %h", nm, e, g); end end

module dmcca_top_tb
  import dmcca_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================================================
  // Stimulus and observed signals.
  logic        ref_clk_i = 1'b0;
  logic        rst_b_i   = 1'b0;
  logic [5:0]  adr       = 6'h00;
  logic        rd_s      = 1'b0;
  logic        wr_s      = 1'b0;
  logic        idle      = 1'b0;
  logic        t0        = 1'b0;
  logic [31:0] wd        = 32'h0000_0000;
  logic [2:0]  lvl       = 3'h1;
  logic [31:0] rdat;
  logic        wt;
  logic        irq;
  logic [2:0]  pin;
  logic [2:0]  po;
  logic [2:0]  poe;
  logic [7:0]  rv;
  int          n_fail    = 0;
  int          n_tests   = 0;
  int          cyc       = 0;

  // Design and far side; gpio keeps P1.3 high while the unit leaves it alone.
  dmcca_top u_dmcca_top (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .avs_address_i(adr),
    .avs_read_i(rd_s), .avs_write_i(wr_s), .avs_writedata_i(wd), .avs_byteenable_i(4'h1),
    .avs_readdata_o(rdat), .avs_waitrequest_o(wt), .idle_i(idle), .t0_ovf_i(t0), .irq_o(irq),
    .pin_i(pin), .pin_o(po), .pin_oe_b_o(poe), .gpio_out_i(3'h2), .gpio_oe_b_i(3'h7));
  dmcca_pin_model u_dmcca_pin_model (.lvl_i(lvl), .drv_i(po), .oe_b_i(poe), .wire_o(pin));

  // Clock at 20 MHz; a hang is cut short long after all scenarios should end.
  always #25 ref_clk_i = ~ref_clk_i;
  always @(posedge ref_clk_i)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      n_fail++;
      complete_run();
    end
  end

  // ==========================================================================
  // Bus, pulse and report tasks.
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : complete_run

  // One request held until waitrequest is seen low at a rising edge.
  task automatic bus(input logic w, input logic [5:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    adr <= a; wd <= 32'(d); wr_s <= w; rd_s <= ~w;
    do @(posedge ref_clk_i); while (wt !== 1'b0);
    rv = rdat[7:0];
    wr_s <= 1'b0; rd_s <= 1'b0;
  endtask : bus

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [5:0] a, input logic [7:0] e, input string nm);
    bus(1'b0, a, 8'h00);
    `CHK(nm, e, rv)
  endtask : rd

  task automatic pulse(input int n);
    repeat (n)
    begin
      @(posedge ref_clk_i) t0 <= 1'b1;
      @(posedge ref_clk_i) t0 <= 1'b0;
    end
  endtask : pulse

  task automatic cy(input int n);
    repeat (n) @(posedge ref_clk_i);
  endtask : cy

  // ==========================================================================
  // Scenarios.
  task automatic t_reset();
    rd(OFF_CTL, 8'h00, "ctl");
    rd(6'h28, 8'h00, "unmapped");
    `CHK("gpio", 1'b1, po[1])
    $display("done reset");
  endtask : t_reset

  // Timer 0 source; idle halts only with the idle-stop bit; stop halts all.
  task automatic t_src();
    wr(OFF_MODE, 8'h84); wr(OFF_CTL, 8'h40); pulse(3);
    @(posedge ref_clk_i) idle <= 1'b1;
    pulse(2); wr(OFF_MODE, 8'h04); pulse(2);
    @(posedge ref_clk_i) idle <= 1'b0;
    wr(OFF_CTL, 8'h00); pulse(2);
    rd(OFF_CNT_LO, 8'h05, "t0 count");
    wr(OFF_CNT_LO, 8'h00); wr(OFF_MODE, 8'h06); wr(OFF_CTL, 8'h40);
    repeat (4)
    begin
      lvl[0] <= 1'b0; cy(8); lvl[0] <= 1'b1; cy(8);
    end
    wr(OFF_CTL, 8'h00);
    rd(OFF_CNT_LO, 8'h04, "ext count");
    $display("done source");
  endtask : t_src

  task automatic t_ovf();
    wr(OFF_MODE, 8'h05); wr(OFF_CNT_LO, 8'hff); wr(OFF_CNT_HI, 8'hff); wr(OFF_CTL, 8'h40);
    pulse(1); cy(2);
    `CHK("irq ovf", 1'b1, irq)
    rd(OFF_CTL, 8'hc0, "ovf flag");
    wr(OFF_CTL, 8'h00); cy(2);
    `CHK("irq clr", 1'b0, irq)
    $display("done overflow");
  endtask : t_ovf

  // Both edges armed; counter held so the grabbed value is exact.
  task automatic t_cap();
    wr(OFF_CNT_LO, 8'h34); wr(OFF_CNT_HI, 8'h12); wr(OFF_UMODE, 8'h31);
    lvl[1] <= 1'b1; cy(8);
    rd(OFF_GRAB_LO, 8'h34, "grab lo");
    rd(OFF_GRAB_HI, 8'h12, "grab hi");
    rd(OFF_CTL, 8'h01, "cap flag");
    `CHK("irq cap", 1'b1, irq)
    wr(OFF_CTL, 8'h00); wr(OFF_CNT_LO, 8'h56);
    lvl[1] <= 1'b0; cy(8);
    rd(OFF_GRAB_LO, 8'h56, "grab fall");
    wr(OFF_UMODE, 8'h00);
    $display("done capture");
  endtask : t_cap

  task automatic t_hso();
    wr(6'h20, 8'h05); wr(6'h24, 8'h00); wr(OFF_CNT_LO, 8'h00); wr(OFF_CNT_HI, 8'h00);
    wr(OFF_UMODE + OFF_UMODE_STP, 8'h4c); wr(OFF_MODE, 8'h04); wr(OFF_CTL, 8'h40);
    pulse(5); cy(4);
    `CHK("hso pin", 2'h1, {poe[2], po[2]})
    rd(OFF_CTL, 8'h42, "hit flag");
    wr(OFF_CTL, 8'h40); wr(OFF_UMODE + OFF_UMODE_STP, 8'h0c); wr(OFF_CNT_LO, 8'h04);
    pulse(1); cy(4);
    rd(OFF_CTL, 8'h40, "no cmp");
    `CHK("hold pin", 1'b1, po[2])
    $display("done hso");
  endtask : t_hso

  task automatic t_pwm();
    wr(OFF_CTL, 8'h00); wr(OFF_UMODE, 8'h42); wr(OFF_GRAB_LO, 8'h80); wr(OFF_GRAB_HI, 8'h20);
    wr(OFF_CNT_LO, 8'h10); cy(3);
    `CHK("pwm low", 1'b0, po[1])
    wr(OFF_CNT_LO, 8'h90); cy(3);
    `CHK("pwm high", 1'b1, po[1])
    wr(OFF_CNT_LO, 8'hff); wr(OFF_CTL, 8'h40); pulse(1); wr(OFF_CTL, 8'h00);
    wr(OFF_CNT_LO, 8'h30); cy(3);
    `CHK("pwm reload", 1'b1, po[1])
    $display("done pwm");
  endtask : t_pwm

  // Both prescaled sources; run stays set for exactly 60 cycles each time.
  task automatic t_div();
    wr(OFF_CNT_LO, 8'h00); wr(OFF_MODE, 8'h00); wr(OFF_CTL, 8'h40); cy(57); wr(OFF_CTL, 8'h00);
    rd(OFF_CNT_LO, 8'h0a, "div6 count");
    wr(OFF_CNT_LO, 8'h00); wr(OFF_MODE, 8'h02); wr(OFF_CTL, 8'h40); cy(57); wr(OFF_CTL, 8'h00);
    rd(OFF_CNT_LO, 8'h1e, "div2 count");
    $display("done divide");
  endtask : t_div

  // Main sequence: reset for 10 cycles, then every scenario in turn.
  initial
  begin
    repeat (10) @(posedge ref_clk_i);
    rst_b_i <= 1'b1;
    t_reset(); t_src(); t_ovf(); t_cap(); t_hso(); t_pwm(); t_div();
    complete_run();
  end
endmodule : dmcca_top_tb

`default_nettype wire
